// ===== design/coproc_glue_consts.svh
// timing counts and decode positions for the coprocessor reset glue
// assumes a 100 MHz clk_sys and a half-rate system clock level on sclk
`ifndef COPROC_GLUE_CONSTS_SVH
`define COPROC_GLUE_CONSTS_SVH

`define CLK_PERIOD_NS     10
`define SEQ_RESET_SCLK    64
`define SEQ_INIT_SCLK     32
`define SEQ_TOTAL_SCLK    96
`define SEQ_CNT_W         7
`define SEQ_CNT_RST       7'h60
`define TAP64_BIT         6
`define TAP32_BIT         5
`define AF_MIN_NS         26
`define AF_MIN_CYC        ((`AF_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AF_CNT_W          3
`define PORT_A0_BIT       0
`define PORT_A1_BIT       1
`define PORT_A2_BIT       2
`define PORT_A3_BIT       3
`define PORT_A4_BIT       4
`define ERR_N_RST         1'b0

`endif

// ===== design/coproc_glue_pkg.sv
// types shared by the coprocessor reset glue
// assumes the constants header is included by the design files
package coproc_glue_pkg;

	// gray coded along idle -> reset -> init; init -> idle flips both bits
	typedef enum logic [1:0]
	{
		SEQ_IDLE  = 2'b00,
		SEQ_RESET = 2'b01,
		SEQ_INIT  = 2'b11
	} seq_state_t;

endpackage : coproc_glue_pkg

// ===== design/seq_counter.sv
// cascaded sequence counter with 64 and 32 taps
// assumes tick is a one-cycle pulse per system-clock period
`timescale 1ns/100ps
`include "coproc_glue_consts.svh"

module seq_counter
#(
	parameter int CNT_W = `SEQ_CNT_W
)
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic ce,
	input  wire logic clear,
	input  wire logic tick,
	output logic      count64_tap,
	output logic      count32_tap
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             terminal;

	assign count64_tap = cnt_q[`TAP64_BIT];
	assign count32_tap = cnt_q[`TAP32_BIT];
	assign terminal    = count64_tap & count32_tap;

	always_comb
	begin
		cnt_d = cnt_q;
		if (clear)
			cnt_d = '0;
		else if (tick && !terminal)
			cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
	end

	// comes out of reset already terminal, so no sequence runs at power up
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			cnt_q <= CNT_W'(`SEQ_CNT_RST);
		else if (ce)
			cnt_q <= cnt_d;
	end

endmodule : seq_counter

// ===== design/local_flag_gen.sv
// forced local access flag for coprocessor cycles
// assumes ale_n, a31, mem_io_select and sclk are synchronous levels
`timescale 1ns/100ps
`include "coproc_glue_consts.svh"

module local_flag_gen
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic ce,
	input  wire logic sclk,
	input  wire logic addr_latch_enable_n,
	input  wire logic addr_a31,
	input  wire logic mem_io_select,
	output logic      flag_oe_n
);

	logic                 ale_q;
	logic [`AF_CNT_W-1:0] hold_q;
	logic [`AF_CNT_W-1:0] hold_d;
	logic                 active_q;
	logic                 active_d;
	logic                 ale_edge;
	logic                 hold_ok;

	assign ale_edge = ale_q ^ addr_latch_enable_n;
	assign hold_ok  = (hold_q >= `AF_CNT_W'(`AF_MIN_CYC));

	always_comb
	begin
		hold_d = hold_q;
		if (ale_edge)
			hold_d = '0;
		else if (!hold_ok)
			hold_d = hold_q + `AF_CNT_W'(1);
		active_d = (!addr_latch_enable_n && sclk && addr_a31 &&
			!mem_io_select && hold_ok)
			|| (active_q && !sclk);
		// a latch enable change starts the next cycle: let go first
		if (ale_edge)
			active_d = 1'b0;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ale_q     <= 1'b1;
			hold_q    <= '0;
			active_q  <= 1'b0;
			flag_oe_n <= 1'b1;
		end
		else if (ce)
		begin
			ale_q     <= addr_latch_enable_n;
			hold_q    <= hold_d;
			active_q  <= active_d;
			flag_oe_n <= !active_d;
		end
	end

endmodule : local_flag_gen

// ===== design/coproc_reset_sync_glue.sv
// top of the coprocessor reset and bus glue
// assumes all pin inputs are synchronous to clk_sys and sclk is the
// half-rate system clock presented as a level
`timescale 1ns/100ps
`include "coproc_glue_consts.svh"

// What this block does
// - port write pulses select, clearing counter
// - sync reset is inverted 64 tap
// - sync reset falls on sclk falling edge
// - coprocessor reset high at least 64 sclk
// - ready held low until both taps active
// - stall 32 more sclk after reset falls
// - release ready 96 sclk after write
// - reset out is port reset or cpu reset
// - port reset term may be disabled
// - local flag active on coprocessor accesses
// - flag asserts no earlier than 26 ns
// - flag drops before next latch enable
// - flag is tri-state, driven only when active
// - flag set by ale, sclk, a31, io
// - error low from reset to first ready
// - decode io write, cs, a4, a3..a1 low
module coproc_reset_sync_glue
	import coproc_glue_pkg::*;
#(
	parameter bit PORT_RESET_EN = 1'b1
)
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       ce,
	input  wire logic       sclk,
	input  wire logic       io_write_n,
	input  wire logic       coproc_cs_n,
	input  wire logic [4:0] io_addr,
	input  wire logic       cpu_reset_in,
	input  wire logic       bus_ready_n,
	input  wire logic       addr_latch_enable_n,
	input  wire logic       addr_a31,
	input  wire logic       mem_io_select,
	output logic            port_decode_sel_n,
	output logic            reset_port_select,
	output logic            sync_port_reset,
	output logic            coproc_reset_out,
	output logic            io_ready_out,
	output logic            io_ready_oe_n,
	output logic            local_access_flag_n_out,
	output logic            local_access_flag_n_oe_n,
	output logic            cpu_error_out_n
);

	function automatic logic port_hit(input logic wr_n, input logic cs_n,
		input logic [4:0] a);
		port_hit = !wr_n && !cs_n && a[`PORT_A4_BIT] &&
			!a[`PORT_A3_BIT] && !a[`PORT_A2_BIT] && !a[`PORT_A1_BIT];
	endfunction : port_hit

	// edge of a sampled level; rise picks low-to-high, else high-to-low
	function automatic logic level_edge(input logic prev, input logic cur,
		input logic rise);
		level_edge = rise ? (!prev && cur) : (prev && !cur);
	endfunction : level_edge

	// sclk edges and the port decode
	logic       sclk_q;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       decode_hit;
	logic       reset_hit;
	logic       reset_hit_q;
	logic       seq_start;

	// sclk comes in as a level, so its edges are seen one clk_sys late;
	// every count below is in these sampled edges
	assign sclk_rise  = level_edge(sclk_q, sclk, 1'b1);
	assign sclk_fall  = level_edge(sclk_q, sclk, 1'b0);
	assign decode_hit = port_hit(io_write_n, coproc_cs_n, io_addr);
	assign reset_hit  = decode_hit && io_addr[`PORT_A0_BIT];
	// the write is stretched by the stall, so only its first cycle starts
	// a sequence; a held write does not keep the counter cleared
	assign seq_start  = level_edge(reset_hit_q, reset_hit, 1'b1);

	// sclk tracker; reset to the idle low level so no false edge follows
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			sclk_q <= 1'b0;
		else if (ce)
			sclk_q <= sclk;
	end

	// write tracker: remembers that this port write was already taken
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			reset_hit_q <= 1'b0;
		else if (ce)
			reset_hit_q <= reset_hit;
	end

	// cascaded counter, one count per sclk period
	// ticks only while ce is high, like every other register here
	logic count64_tap;
	logic count32_tap;
	logic both_taps;

	seq_counter #(
		.CNT_W (`SEQ_CNT_W)
	) u_seq_counter (
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.ce          (ce),
		.clear       (seq_start),
		.tick        (sclk_rise),
		.count64_tap (count64_tap),
		.count32_tap (count32_tap)
	);

	// the counter sits terminal after power up and after each sequence,
	// so both taps stay set and ready stays released between writes
	assign both_taps = count64_tap && count32_tap;

	// synchronised port reset
	// raised at once on the write, but only ever lowered on a sampled
	// sclk fall, which keeps the coprocessor's bus clock in phase
	logic sync_rst_q;
	logic sync_rst_d;

	always_comb
	begin
		sync_rst_d = sync_rst_q;
		if (seq_start)
			sync_rst_d = 1'b1;
		else if (sclk_fall)
			sync_rst_d = !count64_tap;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			sync_rst_q <= 1'b0;
		else if (ce)
			sync_rst_q <= sync_rst_d;
	end

	// one port write, counted in sampled sclk rises after it is taken:
	//   0   ready pulled low and port reset raised
	//   64  port reset drops at the next sclk fall, in phase with the host
	//   96  both taps set; ready is released on the following edge
	// a fresh write restarts this timeline wherever it stands
	// sequence state: reset phase, then init phase, then ready released
	seq_state_t state_q;
	seq_state_t state_d;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			SEQ_IDLE:
			begin
				if (seq_start)
					state_d = SEQ_RESET;
			end
			SEQ_RESET:
			begin
				// leave only once the reset has really dropped on a fall
				if (!sync_rst_q && count64_tap)
					state_d = SEQ_INIT;
			end
			SEQ_INIT:
			begin
				// the counter stops at both taps, so this cannot overrun
				if (both_taps)
					state_d = SEQ_IDLE;
			end
			default:
			begin
				// unused code: fall back to idle rather than stall forever
				state_d = SEQ_IDLE;
			end
		endcase
		// a fresh write wins over every state
		if (seq_start)
			state_d = SEQ_RESET;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			state_q <= SEQ_IDLE;
		else if (ce)
			state_q <= state_d;
	end

	// processor error strap: low from cpu reset until the first ready
	// it comes out of reset low, so a host that leaves its own reset
	// early still sees the coprocessor as present
	logic err_n_q;
	logic err_n_d;
	logic err_wait_q;
	logic err_wait_d;

	always_comb
	begin
		err_n_d    = err_n_q;
		err_wait_d = err_wait_q;
		// cpu reset wins over a ready seen in the same cycle
		if (cpu_reset_in)
		begin
			err_n_d    = 1'b0;
			err_wait_d = 1'b1;
		end
		else if (err_wait_q && !bus_ready_n)
		begin
			err_n_d    = 1'b1;
			err_wait_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			err_n_q    <= `ERR_N_RST;
			err_wait_q <= 1'b1;
		end
		else if (ce)
		begin
			err_n_q    <= err_n_d;
			err_wait_q <= err_wait_d;
		end
	end

	// forced local access flag
	// the flag pin is shared with the memory controller, so it is only
	// driven while asserted and is let go the moment latch enable moves
	logic flag_oe_n;

	local_flag_gen u_local_flag_gen (
		.clk_sys             (clk_sys),
		.sys_rst             (sys_rst),
		.ce                  (ce),
		.sclk                (sclk),
		.addr_latch_enable_n (addr_latch_enable_n),
		.addr_a31            (addr_a31),
		.mem_io_select       (mem_io_select),
		.flag_oe_n           (flag_oe_n)
	);

	assign local_access_flag_n_oe_n = flag_oe_n;

	// output next values; the two tri-state values are held low so the
	// pins only ever pull to their active level
	logic decode_sel_n_d;
	logic port_select_d;
	logic coproc_rst_d;
	logic ready_value_d;
	logic ready_oe_n_d;
	logic flag_value_d;

	always_comb
	begin
		decode_sel_n_d = !decode_hit;
		port_select_d  = reset_hit;
		coproc_rst_d   = cpu_reset_in
			|| (PORT_RESET_EN && sync_rst_d);
		ready_value_d  = 1'b0;
		// state_d, not state_q, so the stall starts with the write's edge
		ready_oe_n_d   = (state_d == SEQ_IDLE);
		flag_value_d   = 1'b0;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			port_decode_sel_n       <= 1'b1;
			reset_port_select       <= 1'b0;
			sync_port_reset         <= 1'b0;
			coproc_reset_out        <= 1'b1;
			io_ready_out            <= 1'b0;
			io_ready_oe_n           <= 1'b1;
			local_access_flag_n_out <= 1'b0;
			cpu_error_out_n         <= `ERR_N_RST;
		end
		else if (ce)
		begin
			port_decode_sel_n       <= decode_sel_n_d;
			reset_port_select       <= port_select_d;
			sync_port_reset         <= sync_rst_d;
			coproc_reset_out        <= coproc_rst_d;
			io_ready_out            <= ready_value_d;
			io_ready_oe_n           <= ready_oe_n_d;
			local_access_flag_n_out <= flag_value_d;
			cpu_error_out_n         <= err_n_d;
		end
	end

endmodule : coproc_reset_sync_glue

// ===== sim/host_model.sv
// far-side model: phase clock, latch enable and bus ready
// assumes clk_sys is the only timebase
`timescale 1ns/100ps
module host_model
(
	input  wire logic clk_sys,
	output logic      sclk,
	output logic      addr_latch_enable_n,
	output logic      bus_ready_n
);
	logic [3:0] ph;
	initial
	begin
		ph = 4'h0;
		sclk = 1'b0;
		addr_latch_enable_n = 1'b1;
		bus_ready_n = 1'b1;
	end
	// latch enable low for half of a 16-cycle bus cycle, long enough
	// for the flag's settle delay to run out
	always @(negedge clk_sys)
	begin
		sclk <= ~sclk;
		ph <= ph + 4'h1;
		addr_latch_enable_n <= ph[3];
		bus_ready_n <= ph != 4'h9;
	end
endmodule : host_model

// ===== sim/glue_sva.sv
// assertions on the reset glue top ports
// assumes ce held high and sclk toggling every clk_sys cycle
`timescale 1ns/100ps
module glue_sva
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic cpu_reset_in,
	input wire logic addr_latch_enable_n,
	input wire logic reset_port_select,
	input wire logic sync_port_reset,
	input wire logic coproc_reset_out,
	input wire logic io_ready_oe_n,
	input wire logic local_access_flag_n_oe_n,
	input wire logic cpu_error_out_n
);
	logic [8:0] age_q;
	logic [8:0] age_d;
	// cycles since the reset port was last selected, saturating
	always_comb
	begin
		age_d = (age_q == 9'h1ff) ? age_q : age_q + 9'h001;
		if (reset_port_select)
			age_d = 9'h000;
	end
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			age_q <= 9'h1ff;
		else
			age_q <= age_d;
	end
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	or_reset_a: assert property (cpu_reset_in |=> coproc_reset_out)
		else $error("reset out low under cpu reset");
	reset_len_a: assert property ($fell(sync_port_reset) |->
		age_q inside {[122:134]}) else $error("port reset length");
	sync_phase_a: assert property ($fell(sync_port_reset) |->
		!$past(sclk) && $past(sclk, 2)) else $error("reset end phase");
	stall_a: assert property ($fell(sync_port_reset) |->
		##60 !io_ready_oe_n) else $error("stall too short");
	ready_rel_a: assert property ($rose(io_ready_oe_n) |->
		age_q inside {[186:198]}) else $error("ready release time");
	err_low_a: assert property (cpu_reset_in |=> !cpu_error_out_n)
		else $error("error strap high in reset");
	flag_set_a: assert property ($fell(local_access_flag_n_oe_n) |->
		$past(sclk) && !$past(addr_latch_enable_n, 3)) else $error("flag early");
	flag_clr_a: assert property ($changed(addr_latch_enable_n) |=>
		local_access_flag_n_oe_n) else $error("flag not dropped");
	cover property ($fell(sync_port_reset));
	cover property ($rose(io_ready_oe_n));
	cover property ($fell(local_access_flag_n_oe_n));
endmodule : glue_sva

bind coproc_reset_sync_glue glue_sva i_glue_sva (.clk_sys, .sys_rst, .sclk,
	.cpu_reset_in, .addr_latch_enable_n, .reset_port_select,
	.sync_port_reset, .coproc_reset_out, .io_ready_oe_n,
	.local_access_flag_n_oe_n, .cpu_error_out_n);

// ===== sim/tb.sv
// self-checking bench for the coprocessor reset glue
// assumes host_model drives sclk, latch enable and bus ready
`timescale 1ns/100ps
module tb;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        ce = 1'b1;
	logic        io_write_n = 1'b1;
	logic        coproc_cs_n = 1'b1;
	logic [4:0]  io_addr = 5'h00;
	logic        cpu_reset_in = 1'b1;
	logic        addr_a31 = 1'b1;
	logic        mem_io_select = 1'b0;
	logic        sclk, bus_ready_n, addr_latch_enable_n, cpu_error_out_n;
	logic        port_decode_sel_n, reset_port_select, sync_port_reset;
	logic        coproc_reset_out, io_ready_oe_n, local_access_flag_n_oe_n;
	logic        io_ready_out, local_access_flag_n_out, alt_reset_out;
	logic [31:0] rnd = 32'h0000_0018;
	logic [5:0]  corner [4] = '{6'h10, 6'h31, 6'h19, 6'h01};
	int          error_cnt = 0;
	int          num_checks = 0;
	int          flags = 0;
	int          i;
	int          n;

	always #5 clk_sys = ~clk_sys;

	coproc_reset_sync_glue i_coproc_reset_sync_glue (.clk_sys, .sys_rst, .ce,
		.sclk, .io_write_n, .coproc_cs_n, .io_addr, .cpu_reset_in,
		.bus_ready_n, .addr_latch_enable_n, .addr_a31, .mem_io_select,
		.port_decode_sel_n, .reset_port_select, .sync_port_reset,
		.coproc_reset_out, .io_ready_out, .io_ready_oe_n,
		.local_access_flag_n_out, .local_access_flag_n_oe_n,
		.cpu_error_out_n);
	// second copy with the port reset term removed
	coproc_reset_sync_glue #(.PORT_RESET_EN(1'b0))
		i_coproc_reset_sync_glue_alt (.clk_sys, .sys_rst, .ce, .sclk,
		.io_write_n, .coproc_cs_n, .io_addr, .cpu_reset_in, .bus_ready_n,
		.addr_latch_enable_n, .addr_a31, .mem_io_select,
		.port_decode_sel_n(), .reset_port_select(), .sync_port_reset(),
		.coproc_reset_out(alt_reset_out), .io_ready_out(),
		.io_ready_oe_n(), .local_access_flag_n_out(),
		.local_access_flag_n_oe_n(), .cpu_error_out_n());
	host_model i_host_model (.clk_sys, .sclk, .addr_latch_enable_n,
		.bus_ready_n);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	function automatic logic dec(input logic [4:0] a, input logic cs);
		return !cs && a[4:1] == 4'h8;
	endfunction : dec

	task automatic chk(input logic seen, input logic exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %0t seen %b want %b", $time, seen, exp);
		end
	endtask : chk

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// one-cycle write, outputs looked at in the cycle after it is taken
	task automatic wr(input logic [4:0] a, input logic cs);
		@(negedge clk_sys);
		io_addr = a;
		coproc_cs_n = cs;
		io_write_n = 1'b0;
		@(negedge clk_sys);
		chk(port_decode_sel_n, !dec(a, cs));
		chk(reset_port_select, dec(a, cs) && a[0]);
		io_write_n = 1'b1;
	endtask : wr

	// rs > 0 issues a second write mid-sequence, which must restart it
	task automatic seq(input int rs);
		int c;
		int r;
		c = 0;
		r = rs;
		while (io_ready_oe_n === 1'b0 && c < 400)
		begin
			if (c == 100)
			begin
				chk(coproc_reset_out, 1'b1);
				chk(sync_port_reset, 1'b1);
				chk(alt_reset_out, 1'b0);
				chk(io_ready_out, 1'b0);
			end
			if (c == 160)
			begin
				chk(coproc_reset_out, 1'b0);
				chk(sync_port_reset, 1'b0);
			end
			@(negedge clk_sys);
			c++;
			if (c == r)
			begin
				wr(5'h11, 1'b0);
				c = 0;
				r = -1;
			end
		end
		chk(c > 184 && c < 198, 1'b1);
		if (c >= 400)
			finish_test();
		$display("sequence test done after %0d", c);
	endtask : seq

	always @(negedge clk_sys)
		if (local_access_flag_n_oe_n === 1'b0)
			flags++;

	initial
	begin
		repeat (8) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(cpu_error_out_n, 1'b0);
		chk(coproc_reset_out, 1'b1);
		chk(alt_reset_out, 1'b1);
		cpu_reset_in = 1'b0;
		for (n = 0; n < 40 && cpu_error_out_n !== 1'b1; n++)
			@(negedge clk_sys);
		chk(cpu_error_out_n, 1'b1);
		if (n >= 40)
			finish_test();
		$display("error strap test done");
		wr(5'h11, 1'b0);
		seq(50);
		for (i = 0; i < 64; i++)
		begin
			rnd = xs(rnd);
			addr_a31 = rnd[6];
			mem_io_select = rnd[7];
			if (i < 4)
				rnd[5:0] = corner[i];
			wr(rnd[4:0], rnd[5]);
			if (dec(rnd[4:0], rnd[5]) && rnd[0])
				seq(0);
		end
		$display("random test done");
		addr_a31 = 1'b0;
		repeat (20) @(negedge clk_sys);
		ce = 1'b0;
		io_addr = 5'h11;
		coproc_cs_n = 1'b0;
		io_write_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(port_decode_sel_n, 1'b1);
		chk(reset_port_select, 1'b0);
		chk(io_ready_oe_n, 1'b1);
		io_write_n = 1'b1;
		ce = 1'b1;
		$display("clock enable test done");
		chk(local_access_flag_n_out, 1'b0);
		chk(flags > 0, 1'b1);
		chk(cpu_error_out_n, 1'b1);
		finish_test();
	end
endmodule : tb
